/* include/supply_osc_cfg.svh */
// Behaviour
// [R01] Both oscillators run in normal mode and only the slow one in sleep.
// [R02] Each oscillator is checked against the other for drift and stalls.
// [R03] An oscillator fault sends the device to sleep at once.
// [R04] A sleep entry caused by an oscillator fault leaves all flags alone.
// [R05] A software sleep request puts the device into its sleep state.
// [R06] A filtered interface supply undervoltage causes sleep and a flag.
// [R07] A filtered auxiliary regulator overcurrent turns that output off.
// [R08] After that shutdown the device sleeps and sets the supply flag.
// [R09] A filtered I/O supply undervoltage sets the I/O supply low flag.
// [R10] That flag clears by write only after a filtered supply recovery.
// [R11] The flag being set blocks GPIO functions and GPIO wake-up.
// [R12] Each filter counter restarts when its condition goes away.
`ifndef SUPPLY_OSC_CFG_SVH
`define SUPPLY_OSC_CFG_SVH
`define MAIN_OSC_KHZ 14000
`define SLEEP_OSC_KHZ 100
`define REF_CLK_MHZ 200
`define FILT_W 16
`define FILT_DEFAULT 16'h0064
`define RATIO_NOM (`MAIN_OSC_KHZ / `SLEEP_OSC_KHZ)
`define RATIO_TOL 14
`define STUCK_LIMIT 16'h0FA0
`endif

/* include/supply_osc_pkg.sv */
package supply_osc_pkg;
  typedef enum logic [1:0] {ST_NORMAL, ST_SLEEP} pwr_state_t;
endpackage

/* include/filter_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface filter_if #(parameter int W = 16);
  logic         cond;
  logic [W-1:0] limit;
  logic         hit;
  modport ctl (output cond, output limit, input hit);
  modport flt (input cond, input limit, output hit);
endinterface
`default_nettype wire

/* rtl/fault_filter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "supply_osc_cfg.svh"
module fault_filter #(parameter int W = `FILT_W)
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  filter_if.flt     f
);
  logic [W-1:0] cnt_reg;

  // [R12] restart on release
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || !f.cond)
      cnt_reg <= '0;
    else if (cnt_reg != f.limit)
      cnt_reg <= cnt_reg + W'(1);
  end

  assign f.hit = f.cond && (cnt_reg == f.limit);

  // [R12] count restarts
  property p_restart;
    @(posedge ref_clk) disable iff (!nrst) !f.cond |=> cnt_reg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("filter not reset"); // [R12]
endmodule // fault_filter
`default_nettype wire

/* rtl/supply_osc_fault_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "supply_osc_cfg.svh"
module supply_osc_fault_monitor #(
  parameter int FW = `FILT_W
)
(
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          mainOscTick,
  input  wire logic          sleepOscTick,
  input  wire logic          sleepRequest,
  input  wire logic          wakeEvent,
  input  wire logic          gpioWakePin,
  input  wire logic [FW-1:0] filterLimit,
  input  wire logic          ifaceSupplyLow,
  input  wire logic          auxOverCurrent,
  input  wire logic          ioSupplyLowFall,
  input  wire logic          ioSupplyOkRise,
  input  wire logic          supplyErrClear,
  input  wire logic          ioLowClear,
  output logic               mainOscEnable,
  output logic               sleepOscEnable,
  output logic               sleepMode,
  output logic               auxRegEnable,
  output logic               supplyErrSleepFlag,
  output logic               io_supply_low_flag,
  output logic               gpioEnable,
  output logic               oscFault
);
  supply_osc_pkg::pwr_state_t state_reg;
  logic [FW-1:0] mainCnt_reg;
  logic [FW-1:0] stuckCnt_reg;
  logic          ioRecovered_reg;
  logic          driftArmed_reg;
  logic          oscErr;
  logic          gpioWake;

  //////////////////////////////////////////////////////////////////////////
  filter_if #(.W(FW)) fIface ();
  filter_if #(.W(FW)) fAux ();
  filter_if #(.W(FW)) fIoLow ();
  filter_if #(.W(FW)) fIoOk ();
  assign fIface.cond  = ifaceSupplyLow && state_reg == supply_osc_pkg::ST_NORMAL;
  assign fAux.cond    = auxOverCurrent && auxRegEnable;
  assign fIoLow.cond  = ioSupplyLowFall;
  assign fIoOk.cond   = ioSupplyOkRise;
  assign fIface.limit = filterLimit;
  assign fAux.limit   = filterLimit;
  assign fIoLow.limit = filterLimit;
  assign fIoOk.limit  = filterLimit;
  fault_filter #(.W(FW)) uIface (.ref_clk(ref_clk), .nrst(nrst), .f(fIface));
  fault_filter #(.W(FW)) uAux   (.ref_clk(ref_clk), .nrst(nrst), .f(fAux));
  fault_filter #(.W(FW)) uIoLow (.ref_clk(ref_clk), .nrst(nrst), .f(fIoLow));
  fault_filter #(.W(FW)) uIoOk  (.ref_clk(ref_clk), .nrst(nrst), .f(fIoOk));

  //////////////////////////////////////////////////////////////////////////
  // [R02] count main ticks per sleep tick; stall guard on both
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || state_reg != supply_osc_pkg::ST_NORMAL || sleepOscTick)
      mainCnt_reg <= '0;
    else if (mainOscTick && mainCnt_reg != '1)
      mainCnt_reg <= mainCnt_reg + FW'(1);
  end

  // [R02] first slow tick after wake only arms
  // a window cut short by sleep would look like drift
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || state_reg != supply_osc_pkg::ST_NORMAL)
      driftArmed_reg <= 1'b0;
    else if (sleepOscTick)
      driftArmed_reg <= 1'b1;
  end

  // [R02] stuck-at watchdog
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || state_reg != supply_osc_pkg::ST_NORMAL || mainOscTick)
      stuckCnt_reg <= '0;
    else if (stuckCnt_reg != FW'(`STUCK_LIMIT))
      stuckCnt_reg <= stuckCnt_reg + FW'(1);
  end

  // drift only judged at a slow edge, stall continuously
  assign oscErr = state_reg == supply_osc_pkg::ST_NORMAL &&
    ((sleepOscTick && driftArmed_reg &&
      (mainCnt_reg < FW'(`RATIO_NOM - `RATIO_TOL) ||
       mainCnt_reg > FW'(`RATIO_NOM + `RATIO_TOL))) ||
     stuckCnt_reg == FW'(`STUCK_LIMIT) ||
     mainCnt_reg == '1);
  assign oscFault = oscErr;

  //////////////////////////////////////////////////////////////////////////
  // [R11] gpio wake only when io supply good
  assign gpioWake = gpioWakePin && !io_supply_low_flag;

  // [R03] [R05] [R06] [R08] sleep entry
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      state_reg <= supply_osc_pkg::ST_NORMAL;
    else
      case (state_reg)
        supply_osc_pkg::ST_NORMAL:
          if (oscErr || sleepRequest || fIface.hit || fAux.hit)
            state_reg <= supply_osc_pkg::ST_SLEEP;
        // [R08] a fresh aux shutdown keeps the device asleep
        supply_osc_pkg::ST_SLEEP:
          if ((wakeEvent || gpioWake) && !fAux.hit)
            state_reg <= supply_osc_pkg::ST_NORMAL;
        default:
          state_reg <= supply_osc_pkg::ST_NORMAL;
      endcase
  end

  // [R01] oscillator enables
  assign sleepMode      = state_reg == supply_osc_pkg::ST_SLEEP;
  assign mainOscEnable  = !sleepMode;
  assign sleepOscEnable = 1'b1;

  // [R07] aux regulator off on overcurrent, back on at wake
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      auxRegEnable <= 1'b1;
    else if (fAux.hit)
      auxRegEnable <= 1'b0;
    else if (state_reg == supply_osc_pkg::ST_SLEEP && (wakeEvent || gpioWake))
      auxRegEnable <= 1'b1;
  end

  // [R04] [R06] [R08] flag untouched on osc faults; set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      supplyErrSleepFlag <= 1'b0;
    else if (!oscErr && (fIface.hit || fAux.hit))
      supplyErrSleepFlag <= 1'b1;
    else if (supplyErrClear)
      supplyErrSleepFlag <= 1'b0;
  end

  // [R10] recovery seen for filter time
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || !ioSupplyOkRise)
      ioRecovered_reg <= 1'b0;
    else if (fIoOk.hit)
      ioRecovered_reg <= 1'b1;
  end

  // [R09] [R10] set wins; clear only after recovery
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      io_supply_low_flag <= 1'b0;
    else if (fIoLow.hit)
      io_supply_low_flag <= 1'b1;
    else if (ioLowClear && ioRecovered_reg)
      io_supply_low_flag <= 1'b0;
  end

  // [R11] gpio function gate
  assign gpioEnable = !io_supply_low_flag;

  //////////////////////////////////////////////////////////////////////////
  sequence s_oscBad;
    oscErr && state_reg == supply_osc_pkg::ST_NORMAL;
  endsequence
  sequence s_inSleep;
    state_reg == supply_osc_pkg::ST_SLEEP;
  endsequence

  property p_oscSleep;
    @(posedge ref_clk) disable iff (!nrst) s_oscBad |=> s_inSleep;
  endproperty
  a_oscSleep: assert property (p_oscSleep) else $error("no sleep on osc"); // [R03]

  property p_oscNoFlag;
    @(posedge ref_clk) disable iff (!nrst)
      oscErr && !supplyErrClear |=> $stable(supplyErrSleepFlag);
  endproperty
  a_oscNoFlag: assert property (p_oscNoFlag) else $error("flag on osc"); // [R04]

  property p_reqSleep;
    @(posedge ref_clk) disable iff (!nrst)
      sleepRequest && !sleepMode |=> sleepMode;
  endproperty
  a_reqSleep: assert property (p_reqSleep) else $error("request ignored"); // [R05]

  property p_ifaceErr;
    @(posedge ref_clk) disable iff (!nrst)
      fIface.hit && !oscErr |=> sleepMode && supplyErrSleepFlag;
  endproperty
  a_ifaceErr: assert property (p_ifaceErr) else $error("iface fault lost"); // [R06]

  property p_auxOff;
    @(posedge ref_clk) disable iff (!nrst) fAux.hit |=> !auxRegEnable;
  endproperty
  a_auxOff: assert property (p_auxOff) else $error("aux still on"); // [R07]

  property p_auxSleep;
    @(posedge ref_clk) disable iff (!nrst)
      fAux.hit && !oscErr |=> sleepMode && supplyErrSleepFlag;
  endproperty
  a_auxSleep: assert property (p_auxSleep) else $error("aux no sleep"); // [R08]

  property p_ioSet;
    @(posedge ref_clk) disable iff (!nrst) fIoLow.hit |=> io_supply_low_flag;
  endproperty
  a_ioSet: assert property (p_ioSet) else $error("io flag not set"); // [R09]

  property p_ioEarlyClr;
    @(posedge ref_clk) disable iff (!nrst)
      io_supply_low_flag && !ioRecovered_reg |=> io_supply_low_flag;
  endproperty
  a_ioEarlyClr: assert property (p_ioEarlyClr) else $error("early clear"); // [R10]

  property p_gpio;
    @(posedge ref_clk) disable iff (!nrst) gpioEnable == !io_supply_low_flag;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio gate wrong"); // [R11]

  property p_osc;
    @(posedge ref_clk) disable iff (!nrst)
      sleepOscEnable && (mainOscEnable == !sleepMode);
  endproperty
  a_osc: assert property (p_osc) else $error("osc enable wrong"); // [R01]

  property p_stuck;
    @(posedge ref_clk) disable iff (!nrst)
      stuckCnt_reg == FW'(`STUCK_LIMIT) && !sleepMode |-> oscErr;
  endproperty
  a_stuck: assert property (p_stuck) else $error("stall missed"); // [R02]
endmodule // supply_osc_fault_monitor
`default_nettype wire

/* verif/test_supply_osc_fault_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module test_supply_osc_fault_monitor;
  logic        ref_clk = 0, nrst = 0, mainOscTick = 0, sleepOscTick = 0;
  logic        sleepRequest = 0, wakeEvent = 0, gpioWakePin = 0;
  logic        ifaceSupplyLow = 0, auxOverCurrent = 0, ioSupplyLowFall = 0;
  logic        ioSupplyOkRise = 0, supplyErrClear = 0, ioLowClear = 0;
  logic [15:0] filterLimit = 16'h0004;
  logic        mainOscEnable, sleepOscEnable, sleepMode, auxRegEnable;
  logic        supplyErrSleepFlag, io_supply_low_flag, gpioEnable, oscFault;
  int          errors = 0, samples_checked = 0, tc = 0, lim, n, div = 14;
  bit          run = 1;

  supply_osc_fault_monitor supply_osc_fault_monitor_i (.ref_clk, .nrst,
    .mainOscTick, .sleepOscTick, .sleepRequest, .wakeEvent, .gpioWakePin,
    .filterLimit, .ifaceSupplyLow, .auxOverCurrent, .ioSupplyLowFall,
    .ioSupplyOkRise, .supplyErrClear, .ioLowClear, .mainOscEnable,
    .sleepOscEnable, .sleepMode, .auxRegEnable, .supplyErrSleepFlag,
    .io_supply_low_flag, .gpioEnable, .oscFault);

  always #2.5 ref_clk = ~ref_clk;

  // ratio 2000/14 sits inside the drift window
  always @(negedge ref_clk)
  begin
    tc++;
    mainOscTick <= run && (tc % div == 0);
    sleepOscTick <= run && (tc % 2000 == 0);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic s, input logic e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t value %b expected %b", $time, s, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(2);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    errors++;
    stop_test();
  end

  initial
  begin
    void'($urandom(25973));
    lim = 3 + $urandom % 6;
    filterLimit = 16'(lim);
    cyc(12);
    nrst = 1;
    cyc(1);
    chk(sleepMode, 0);
    chk(mainOscEnable, 1);
    chk(sleepOscEnable, 1);
    chk(gpioEnable, 1);
    ioSupplyLowFall = 1;
    cyc(lim);
    ioSupplyLowFall = 0;
    cyc(2);
    chk(io_supply_low_flag, 0);
    ioSupplyLowFall = 1;
    cyc(lim + 2);
    chk(io_supply_low_flag, 1);
    chk(gpioEnable, 0);
    ioSupplyLowFall = 0;
    pulse(sleepRequest);
    chk(sleepMode, 1);
    chk(mainOscEnable, 0);
    gpioWakePin = 1;
    cyc(3);
    chk(sleepMode, 1);
    gpioWakePin = 0;
    pulse(wakeEvent);
    chk(sleepMode, 0);
    ioSupplyOkRise = 1;
    pulse(ioLowClear);
    chk(io_supply_low_flag, 1);
    cyc(lim + 2);
    pulse(ioLowClear);
    chk(io_supply_low_flag, 0);
    pulse(sleepRequest);
    gpioWakePin = 1;
    cyc(3);
    chk(sleepMode, 0);
    gpioWakePin = 0;
    $display("io supply test done");
    repeat (8)
    begin
      n = $urandom % (lim + 1);
      ifaceSupplyLow = 1;
      cyc(n);
      ifaceSupplyLow = 0;
      cyc(1);
      chk(sleepMode, 0);
    end
    ifaceSupplyLow = 1;
    cyc(lim + 3);
    chk(sleepMode, 1);
    chk(supplyErrSleepFlag, 1);
    ifaceSupplyLow = 0;
    pulse(wakeEvent);
    chk(supplyErrSleepFlag, 1);
    pulse(supplyErrClear);
    auxOverCurrent = 1;
    cyc(lim + 3);
    chk(auxRegEnable, 0);
    chk(sleepMode, 1);
    chk(supplyErrSleepFlag, 1);
    auxOverCurrent = 0;
    pulse(wakeEvent);
    chk(auxRegEnable, 1);
    $display("supply fault test done");
    // stalled main oscillator; slow ticks held so only the stall trips
    run = 0;
    for (n = 0; n < 6000 && oscFault !== 1'b1; n++)
      cyc(1);
    chk(oscFault, 1);
    chk(sleepMode, 0);
    cyc(1);
    chk(sleepMode, 1);
    chk(supplyErrSleepFlag, 1);
    chk(io_supply_low_flag, 0);
    run = 1;
    pulse(wakeEvent);
    chk(sleepMode, 0);
    // main twice too fast; first slow tick after wake only arms
    div = 7;
    for (n = 0; n < 4500 && sleepMode !== 1'b1; n++)
      cyc(1);
    chk(sleepMode, 1);
    chk(supplyErrSleepFlag, 1);
    div = 14;
    pulse(wakeEvent);
    chk(sleepMode, 0);
    pulse(supplyErrClear);
    chk(supplyErrSleepFlag, 0);
    $display("oscillator test done");
    stop_test();
  end
endmodule // test_supply_osc_fault_monitor
`default_nettype wire
